/* include/pxadc_pkg.sv */
// shared constants, types and decode functions for the proximity adc block
package pxadc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_SEL1 = 8'h07;
  localparam logic [7:0] OFF_SEL2 = 8'h08;
  localparam logic [7:0] OFF_SEL3 = 8'h09;
  localparam logic [7:0] OFF_REC = 8'h0A;
  localparam logic [7:0] OFF_STAT = 8'h1F;
  localparam logic [7:0] SEL_RESET = 8'h03;
  localparam logic [7:0] REC_RESET = 8'h70;
  localparam logic [7:0] REC_MASK = 8'h70;
  localparam int REC_LSB = 4;
  localparam int REC_W = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR = 1;
  localparam int STAT_LED = 2;
  localparam int STAT_ROUTE_LSB = 4;
  localparam logic [1:0] CHAN_COUNT = 2'h3;
  localparam logic [1:0] SEL_NONE = 2'h3;

  // ------------------------------------------------------------
  // input selection codes and conversion mode
  // ------------------------------------------------------------
  localparam logic [7:0] CODE_SMALL_IR = 8'h00;
  localparam logic [7:0] CODE_VISIBLE = 8'h02;
  localparam logic [7:0] CODE_LARGE_IR = 8'h03;
  localparam logic [7:0] CODE_NO_PD = 8'h06;
  localparam logic [7:0] CODE_GND = 8'h25;
  localparam logic [7:0] CODE_TEMP = 8'h65;
  localparam logic [7:0] CODE_VDD = 8'h75;
  localparam logic MODE_RAW = 1'b0;
  localparam logic MODE_NORMAL = 1'b1;

  typedef enum logic [2:0] {
    RT_NONE = 3'b000,
    RT_SMALL_IR = 3'b001,
    RT_LARGE_IR = 3'b010,
    RT_VISIBLE = 3'b011,
    RT_NO_PD = 3'b100,
    RT_GND = 3'b101,
    RT_TEMP = 3'b110,
    RT_VDD = 3'b111
  } pxadc_route_e;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int MCLK_NS = 25;
  localparam int ADC_CLK_NS = 50;
  localparam int ADC_DIV = (ADC_CLK_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int DIV_W = (ADC_DIV > 1) ? $clog2(ADC_DIV) : 1;
  localparam int BASE_W = 9;
  localparam int GAIN_W = 3;
  localparam int CNT_W = 16;

  // recovery code to unscaled converter clocks
  function automatic logic [BASE_W-1:0] pxadc_rec_clocks(
    input logic [REC_W-1:0] code
  );
    logic [BASE_W-1:0] n;
    unique case (code)
      3'h0: n = 9'h001;
      3'h1: n = 9'h007;
      3'h2: n = 9'h00F;
      3'h3: n = 9'h01F;
      3'h4: n = 9'h03F;
      3'h5: n = 9'h07F;
      3'h6: n = 9'h0FF;
      3'h7: n = 9'h1FF;
    endcase
    return n;
  endfunction

  // selection code to converter input; raw mode widens the set
  function automatic pxadc_route_e pxadc_route(
    input logic [7:0] code,
    input logic mode
  );
    pxadc_route_e r;
    r = RT_NONE;
    if (code == CODE_LARGE_IR) begin
      r = RT_LARGE_IR;
    end else if (code == CODE_SMALL_IR) begin
      r = RT_SMALL_IR;
    end else if (mode == MODE_RAW) begin
      case (code)
        CODE_VISIBLE: r = RT_VISIBLE;
        CODE_NO_PD: r = RT_NO_PD;
        CODE_GND: r = RT_GND;
        CODE_TEMP: r = RT_TEMP;
        CODE_VDD: r = RT_VDD;
        default: r = RT_NONE;
      endcase
    end
    return r;
  endfunction

endpackage

/* include/pxadc_tmr_if.sv */
// carrier between the sequencer and the scaled wait timer
`timescale 1ns/1ps
interface pxadc_tmr_if;
  import pxadc_pkg::*;
  logic start;
  logic [BASE_W-1:0] base;
  logic [GAIN_W-1:0] gain;
  logic tick;
  logic done;
  modport seq (output start, output base, output gain, output tick,
    input done);
  modport tmr (input start, input base, input gain, input tick,
    output done);
endinterface

/* core/pxadc_wait_timer.sv */
// scaled converter clock wait timer
`timescale 1ns/1ps
module pxadc_wait_timer import pxadc_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // sequencer side
  pxadc_tmr_if.tmr t
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic done;
    logic [CNT_W-1:0] seen;
    logic [CNT_W-1:0] want;
  } pxadc_tmr_s;

  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  pxadc_tmr_s st;
  pxadc_tmr_s nx;

  // ------------------------------------------------------------
  // count
  // ------------------------------------------------------------
  always_comb begin
    nx = st;
    nx.done = 1'b0;
    if (t.start) begin
      nx.cnt = CNT_W'(t.base) << t.gain;
      nx.want = CNT_W'(t.base) << t.gain;
      nx.seen = '0;
    end else if (t.tick && st.cnt != '0) begin
      nx.cnt = st.cnt - 1'b1;
      nx.seen = st.seen + 1'b1;
      nx.done = (st.cnt == CNT_ONE);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign t.done = st.done;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  wait_len_a: assert property (@(posedge mclk) disable iff (reset)
    st.done |-> st.seen == st.want)
    else $error("wait ended after wrong number of converter clocks");

  cover_long_wait_c: cover property (@(posedge mclk) disable iff (reset)
    st.done && st.want > 16'h0200);

endmodule

/* core/pxadc_top.sv */
// proximity channel input selection and recovery sequencing
`timescale 1ns/1ps
// Contract
// - Proximity mode takes 0x03 as the large, 0x00 the small ir diode.
// - Raw mode also takes 0x02 visible, 0x06 no diode, 0x25 ground.
// - In raw mode 0x65 routes the temperature sensor and 0x75 the supply.
// - Raw mode keeps every led driver off and stops proximity detection.
// - Channels two and three own 8-bit codes coded as channel one.
// - All three selection codes reset to 0x03, the large ir diode.
// - A 3-bit code in bits 6:4 waits 1,7,15,...,511 converter clocks.
// - That wait is scaled by two to the gain exponent; one clock is 50 ns.
// - The recovery register resets to 0x70 and bits 3:0 are written zero.
// - Mode bit zero selects raw conversion, one normal proximity.
// - The gain exponent stretches led pulse and integration by two to it.
module pxadc_top import pxadc_pkg::*; #(
  parameter logic [BASE_W-1:0] INTEG_BASE_CLKS = 9'h001
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // settings held elsewhere
  input wire logic [GAIN_W-1:0] prox_gain_exponent,
  input wire logic prox_conversion_mode,
  // measurement request
  input wire logic meas_start,
  input wire logic [1:0] meas_chan,
  // converter front end
  output logic [7:0] adc_code,
  output logic [2:0] adc_route,
  output logic conv_start,
  output logic led_drive,
  output logic meas_done,
  output logic code_err,
  output logic busy
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECOVER = 2'b01,
    ST_INTEG = 2'b10
  } pxadc_state_e;

  typedef struct packed {
    logic [2:0][7:0] sel;
    logic [REC_W-1:0] rec;
    logic [7:0] rdata;
    logic [DIV_W-1:0] div;
    logic tick;
    pxadc_state_e state;
    logic [7:0] code;
    pxadc_route_e route;
    logic [GAIN_W-1:0] gain;
    logic conv_go;
    logic led;
    logic done;
    logic err;
    logic busy;
    logic tstart;
    logic [BASE_W-1:0] tbase;
  } pxadc_top_s;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(ADC_DIV - 1);

  pxadc_top_s st;
  pxadc_top_s nx;
  pxadc_tmr_if t ();

  logic accept;
  logic [7:0] sel_pick;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic [1:0] pxadc_sel_idx(input logic [7:0] a);
    logic [1:0] i;
    unique case (a)
      OFF_SEL1: i = 2'h0;
      OFF_SEL2: i = 2'h1;
      OFF_SEL3: i = 2'h2;
      default: i = SEL_NONE;
    endcase
    return i;
  endfunction

  // a new request is only taken while idle
  assign accept = (st.state == ST_IDLE) && meas_start &&
    (meas_chan < CHAN_COUNT);
  assign sel_pick = (meas_chan < CHAN_COUNT) ? st.sel[meas_chan] : '0;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [1:0] widx;
    logic [1:0] ridx;
    widx = pxadc_sel_idx(addr);
    ridx = pxadc_sel_idx(addr);
    nx = st;
    nx.rdata = '0;
    nx.conv_go = 1'b0;
    nx.done = 1'b0;
    nx.tstart = 1'b0;

    // converter clock enable, 50 ns base
    if (st.div == DIV_LAST) begin
      nx.div = '0;
      nx.tick = 1'b1;
    end else begin
      nx.div = st.div + 1'b1;
      nx.tick = 1'b0;
    end

    // software writes
    if (wr) begin
      if (widx != SEL_NONE) begin
        nx.sel[widx] = wdata;
      end
      if (addr == OFF_REC) begin
        // reserved bits are dropped, so they always read back zero
        nx.rec = wdata[REC_LSB +: REC_W];
      end
    end

    // software reads, data valid the following cycle only
    if (rd) begin
      if (ridx != SEL_NONE) begin
        nx.rdata = st.sel[ridx];
      end else if (addr == OFF_REC) begin
        nx.rdata[REC_LSB +: REC_W] = st.rec;
      end else if (addr == OFF_STAT) begin
        nx.rdata[STAT_BUSY] = st.busy;
        nx.rdata[STAT_ERR] = st.err;
        nx.rdata[STAT_LED] = st.led;
        nx.rdata[STAT_ROUTE_LSB +: 3] = st.route;
      end
    end

    // sequencer
    unique case (st.state)
      ST_IDLE: begin
        nx.led = 1'b0;
        if (accept) begin
          nx.code = sel_pick;
          // code, route and gain are sampled once; the led still follows the live mode
          nx.route = pxadc_route(sel_pick,
            prox_conversion_mode);
          nx.err = (pxadc_route(sel_pick, prox_conversion_mode) ==
            RT_NONE);
          nx.gain = prox_gain_exponent;
          nx.busy = 1'b1;
          nx.tstart = 1'b1;
          nx.tbase = pxadc_rec_clocks(st.rec);
          nx.state = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        nx.led = 1'b0;
        if (t.done) begin
          nx.conv_go = 1'b1;
          // leds only light in proximity mode with a usable code
          nx.led = (prox_conversion_mode == MODE_NORMAL) &&
            !st.err;
          nx.tstart = 1'b1;
          nx.tbase = INTEG_BASE_CLKS;
          nx.state = ST_INTEG;
        end
      end
      ST_INTEG: begin
        // a switch to raw mode cuts the led at the next clock edge
        nx.led = st.led && (prox_conversion_mode == MODE_NORMAL);
        if (t.done) begin
          nx.led = 1'b0;
          nx.done = 1'b1;
          nx.busy = 1'b0;
          nx.state = ST_IDLE;
        end
      end
      default: begin
        nx.led = 1'b0;
        nx.busy = 1'b0;
        nx.state = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.sel <= {3{SEL_RESET}};
      st.rec <= REC_RESET[REC_LSB +: REC_W];
      st.state <= ST_IDLE;
      st.route <= RT_NONE;
    end else begin
      st <= nx;
    end
  end

  // ------------------------------------------------------------
  // timer and outputs
  // ------------------------------------------------------------
  assign t.start = st.tstart;
  assign t.base = st.tbase;
  assign t.gain = st.gain;
  assign t.tick = st.tick;

  pxadc_wait_timer u_timer (
    .mclk (mclk),
    .reset (reset),
    .t (t.tmr)
  );

  assign rdata = st.rdata;
  assign adc_code = st.code;
  assign adc_route = st.route;
  assign conv_start = st.conv_go;
  assign led_drive = st.led;
  assign meas_done = st.done;
  assign code_err = st.err;
  assign busy = st.busy;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sel_reset_a: assert property (
    $fell(reset) |-> st.sel == {3{SEL_RESET}})
    else $error("selection codes not at reset value");

  rec_reset_a: assert property (
    $fell(reset) |-> st.rec == REC_RESET[REC_LSB +: REC_W])
    else $error("recovery code not at reset value");

  rec_reserved_a: assert property (
    rd && addr == OFF_REC |=> (rdata & ~REC_MASK) == 8'h00 &&
      rdata[REC_LSB +: REC_W] == $past(st.rec))
    else $error("recovery register readback wrong");

  large_ir_a: assert property (
    accept && prox_conversion_mode == MODE_NORMAL &&
      sel_pick == CODE_LARGE_IR |=> adc_route == RT_LARGE_IR && !code_err)
    else $error("large ir code not routed");

  raw_ground_a: assert property (
    accept && prox_conversion_mode == MODE_RAW &&
      sel_pick == CODE_GND |=> adc_route == RT_GND && !code_err)
    else $error("ground code not routed in raw mode");

  raw_temp_a: assert property (
    accept && prox_conversion_mode == MODE_RAW &&
      sel_pick == CODE_TEMP |=> adc_route == RT_TEMP)
    else $error("temperature code not routed in raw mode");

  normal_reject_a: assert property (
    accept && prox_conversion_mode == MODE_NORMAL &&
      sel_pick == CODE_VISIBLE |=> code_err && adc_route == RT_NONE)
    else $error("raw only code taken in proximity mode");

  chan_code_a: assert property (
    accept |=> adc_code == $past(sel_pick) && busy)
    else $error("wrong channel code used");

  led_raw_a: assert property (
    prox_conversion_mode == MODE_RAW |=> !led_drive)
    else $error("led driven in raw mode");

  rec_max_a: assert property (
    accept && st.rec == 3'h7 |=> t.start && t.base == 9'h1FF)
    else $error("maximum recovery not 511 clocks");

  rec_min_a: assert property (
    accept && st.rec == 3'h0 ##1 t.start |-> t.base == 9'h001)
    else $error("minimum recovery not one clock");

  conv_after_rec_a: assert property (
    accept && st.rec == 3'h0 && prox_gain_exponent == 3'h0
      |-> ##[4:7] conv_start)
    else $error("short recovery did not end in time");

  small_ir_a: assert property (
    accept && sel_pick == CODE_SMALL_IR |=> adc_route == RT_SMALL_IR &&
      !code_err)
    else $error("small ir code not routed");

  raw_visible_a: assert property (
    accept && prox_conversion_mode == MODE_RAW &&
      sel_pick == CODE_VISIBLE |=> adc_route == RT_VISIBLE && !code_err)
    else $error("visible code not routed in raw mode");

  raw_nopd_a: assert property (
    accept && prox_conversion_mode == MODE_RAW &&
      sel_pick == CODE_NO_PD |=> adc_route == RT_NO_PD && !code_err)
    else $error("no diode code not routed in raw mode");

  raw_vdd_a: assert property (
    accept && prox_conversion_mode == MODE_RAW &&
      sel_pick == CODE_VDD |=> adc_route == RT_VDD && !code_err)
    else $error("supply code not routed in raw mode");

  sel_write_a: assert property (
    wr && addr == OFF_SEL3 |=> st.sel[2] == $past(wdata))
    else $error("third channel code not stored");

  code_hold_a: assert property (
    busy |=> $stable(adc_code) && $stable(adc_route))
    else $error("conversion settings changed mid run");

  gain_scale_a: assert property (
    accept |=> t.start && t.gain == $past(prox_gain_exponent))
    else $error("gain exponent not handed to timer");

  led_window_a: assert property (
    led_drive |-> busy && !meas_done)
    else $error("led lit outside integration");

  done_idle_a: assert property (
    meas_done |-> !busy && !led_drive)
    else $error("led or busy left on at end of measurement");

  cover_prox_c: cover property (
    conv_start && led_drive ##[1:60] meas_done);
  cover_raw_temp_c: cover property (
    accept && prox_conversion_mode == MODE_RAW && sel_pick == CODE_TEMP);
  cover_err_c: cover property (meas_done && code_err);
  cover_back2back_c: cover property (meas_done ##1 accept);

endmodule

/* verif/pxadc_front_model.sv */
// converter front end model: counts conversions, flags stray led drive
`timescale 1ns/1ps
module pxadc_front_model import pxadc_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // block side
  input wire logic conv_start,
  input wire logic led_drive,
  input wire logic meas_done,
  input wire logic prox_conversion_mode,
  // observations
  output logic [15:0] conv_count,
  output logic led_fault
);
  logic integ_r;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      conv_count <= 16'h0000;
      led_fault <= 1'b0;
      integ_r <= 1'b0;
    end else begin
      if (conv_start) begin
        conv_count <= conv_count + 16'h0001;
        integ_r <= 1'b1;
      end else if (meas_done) begin
        integ_r <= 1'b0;
      end
      // a lit led in raw mode or outside integration would burn power
      if (led_drive && prox_conversion_mode == MODE_RAW) begin
        led_fault <= 1'b1;
      end
      if (led_drive && !integ_r && !conv_start) begin
        led_fault <= 1'b1;
      end
    end
  end
endmodule

/* verif/tb_top.sv */
// self-checking bench for the proximity input selection block
`timescale 1ns/1ps
module tb_top;
  import pxadc_pkg::*;
  typedef struct packed {
    logic [7:0] code;
    logic [2:0] route;
    logic led;
    logic err;
  } pxadc_exp_s;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] gain = 3'h0;
  logic mode = 1'b1;
  logic meas_start = 1'b0;
  logic [1:0] meas_chan = 2'h0;
  logic [7:0] rdata, adc_code;
  logic [2:0] adc_route;
  logic conv_start, led_drive, meas_done, code_err, busy, led_fault;
  logic [15:0] conv_count;
  logic rd_d = 1'b0;
  int err_count = 0;
  int samples_checked = 0;
  int meas_total = 0;
  logic [7:0] rd_q[$];
  pxadc_exp_s m_q[$];
  logic [7:0] codes [7] = '{8'h00, 8'h03, 8'h02, 8'h06, 8'h25, 8'h65, 8'h75};

  always #12.5 mclk = ~mclk;

  pxadc_top #(.INTEG_BASE_CLKS(9'h001)) pxadc_top_i (.mclk(mclk),
    .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .prox_gain_exponent(gain), .prox_conversion_mode(mode),
    .meas_start(meas_start), .meas_chan(meas_chan), .adc_code(adc_code),
    .adc_route(adc_route), .conv_start(conv_start), .led_drive(led_drive),
    .meas_done(meas_done), .code_err(code_err), .busy(busy));

  pxadc_front_model pxadc_front_model_i (.mclk(mclk), .reset(reset),
    .conv_start(conv_start), .led_drive(led_drive), .meas_done(meas_done),
    .prox_conversion_mode(mode), .conv_count(conv_count),
    .led_fault(led_fault));

  task automatic chk(input string name, input logic [15:0] seen,
    input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    rd_q.push_back(exp);
    @(posedge mclk);
    rd <= 1'b0;
  endtask

  function automatic logic [2:0] exp_route(input logic [7:0] c,
    input logic m);
    case (c)
      8'h03: return 3'h2;
      8'h00: return 3'h1;
      8'h02: return m ? 3'h0 : 3'h3;
      8'h06: return m ? 3'h0 : 3'h4;
      8'h25: return m ? 3'h0 : 3'h5;
      8'h65: return m ? 3'h0 : 3'h6;
      8'h75: return m ? 3'h0 : 3'h7;
      default: return 3'h0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // one measurement; timing checked here, result by the monitor
  // ------------------------------------------------------------
  task automatic measure(input logic [1:0] ch, input logic [7:0] c,
    input logic m, input logic [2:0] rc, input logic [2:0] g);
    pxadc_exp_s e;
    int n;
    int r;
    int t;
    wr_reg(8'h07 + {6'h00, ch}, c);
    wr_reg(8'h0A, {1'b0, rc, 4'h0});
    @(posedge mclk);
    mode <= m;
    gain <= g;
    meas_chan <= ch;
    meas_start <= 1'b1;
    e.code = c;
    e.route = exp_route(c, m);
    e.led = m & (e.route != 3'h0);
    e.err = (e.route == 3'h0);
    m_q.push_back(e);
    r = ((rc == 3'h0) ? 1 : (1 << (rc + 2)) - 1) << g;
    t = 1 << g;
    meas_total++;
    @(posedge mclk);
    meas_start <= 1'b0;
    n = 1;
    while (conv_start !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    chk("recovery", 16'(n >= 2 * r && n <= 2 * r + 4), 16'h0001);
    n = 0;
    while (meas_done !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    r = int'(n >= 2 * t - 1 && n <= 2 * t + 3);
    chk("integration", 16'(r), 16'h0001);
  endtask

  always @(posedge mclk) begin
    pxadc_exp_s e;
    rd_d <= rd;
    if (rd_d) begin
      chk("rdata", 16'(rdata), 16'(rd_q.pop_front()));
    end
    if (conv_start === 1'b1) begin
      e = (m_q.size() > 0) ? m_q.pop_front() : '0;
      chk("adc_code", {8'h00, adc_code}, {8'h00, e.code});
      chk("route", 16'(adc_route), 16'(e.route));
      chk("led_drive", {15'h0, led_drive}, {15'h0, e.led});
      chk("code_err", {15'h0, code_err}, {15'h0, e.err});
    end
  end

  initial begin
    logic [7:0] d;
    void'($urandom(32'h91E077A4));
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd_reg(8'h07 + 8'(i), 8'h03);
    end
    rd_reg(8'h0A, 8'h70);
    rd_reg(8'h20, 8'h00);
    // idle status: not busy, no error, led off, no route
    rd_reg(8'h1F, 8'h00);
    // independent random contents per channel
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      wr_reg(8'h07 + 8'(i), d);
      rd_reg(8'h07 + 8'(i), d);
    end
    // recovery code is the complement of the gain, as software should
    for (int i = 0; i < 8; i++) begin
      measure(2'(i % 3), 8'h03, 1'b1, 3'(i), ~3'(i));
    end
    // gain scaling pushes the wait past 511 converter clocks
    measure(2'h1, 8'h00, 1'b1, 3'h7, 3'h1);
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 8; i++) begin
        d = (i == 7) ? {1'b1, 7'($urandom)} : codes[i];
        // no diode and ground references are taken in the same sweep
        measure(2'(i % 3), d, 1'(m), 3'h0, 3'h0);
      end
    end
    // channel index 3 (a fourth channel) does not exist and must be ignored
    @(posedge mclk);
    meas_chan <= 2'h3;
    meas_start <= 1'b1;
    @(posedge mclk);
    meas_start <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("busy", {15'h0, busy}, 16'h0000);
    chk("conv_count", conv_count, 16'(meas_total));
    chk("led_fault", {15'h0, led_fault}, 16'h0000);
    report_and_stop();
  end

  initial begin
    repeat (50000) @(posedge mclk);
    err_count++;
    report_and_stop();
  end
endmodule
